// *** seq_pkg.sv ***
// constants, types and register map of the measurement cycle sequencer
`default_nettype none
package seq_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_MS = 100;          // step of every time setting, 0.1 s
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DONE_PULSE_US = 500;    // completed pulse at zero wait
  localparam int DONE_PULSE_CYCLES = CLK_HZ / 1_000_000 * DONE_PULSE_US;
  localparam int NUM_WORKS = 16;
  localparam int WORK_W = 4;
  localparam int VAL_W = 16;
  localparam int TIME_W = 9;
  localparam int WAIT_W = 10;
  localparam int ADDR_W = 8;
  localparam logic [TIME_W-1:0] MEAS_MIN = 9'h001;  // 0.1 s
  localparam logic [TIME_W-1:0] MEAS_MAX = 9'h12C;  // 30.0 s
  localparam logic [TIME_W-1:0] MEAS_RST = 9'h00A;  // 1.0 s
  localparam logic [WAIT_W-1:0] WAIT_MAX = 10'h3E7; // 99.9 s
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 10'h000;
  localparam logic [WAIT_W-1:0] TENTHS_SAT = 10'h3FF;
  // start conditions
  localparam logic [1:0] START_TRIG = 2'h0;
  localparam logic [1:0] START_LOAD = 2'h1;
  localparam logic [1:0] START_DISP = 2'h2;
  // stop conditions
  localparam logic [2:0] STOP_TRIG = 3'h0;
  localparam logic [2:0] STOP_TIME = 3'h1;
  localparam logic [2:0] STOP_TRIG_LOAD = 3'h2;
  localparam logic [2:0] STOP_LOAD = 3'h3;
  localparam logic [2:0] STOP_TRIG_DISP = 3'h4;
  localparam logic [2:0] STOP_DISP = 3'h5;
  localparam logic [2:0] STOP_REPEAT = 3'h6;  // repeat_cycle_mode
  typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_WAIT} state_type;
  typedef struct packed {
    logic [1:0]        start_mode;
    logic [2:0]        stop_mode;
    logic [TIME_W-1:0] meas_time;
    logic [WAIT_W-1:0] repeat_wait_setting;
    logic [VAL_W-1:0]  start_load;
    logic [VAL_W-1:0]  stop_load;
    logic [VAL_W-1:0]  start_disp;
    logic [VAL_W-1:0]  stop_disp;
  } cond_type;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EDIT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MODES = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_TIME = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_WAIT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_START_LOAD = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STOP_LOAD = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_START_DISP = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STOP_DISP = 8'h24;
  // field positions
  localparam int CTRL_SRC_BIT = 0;     // work_source_pins
  localparam int CTRL_MAN_LSB = 4;
  localparam int CTRL_START_BIT = 8;
  localparam int MODE_STOP_LSB = 4;
  localparam int STAT_MEAS_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_WAIT_BIT = 2;
  localparam int STAT_REP_BIT = 3;
  localparam int STAT_WORK_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** measurement_cycle_sequencer.sv ***
// measurement cycle sequencer with its AXI4-Lite register slave
//
// What this block does
// [RQ1] Sixteen condition sets; the selected work's set governs each cycle.
// [RQ2] Work from stored manual number or from select pins.
// [RQ3] Pin mode: four select inputs encode the work.
// [RQ4] Pins sampled just before start, held until end.
// [RQ5] Trigger start: panel start or external input turning on.
// [RQ6] Trigger plus load: start active and load above start-load.
// [RQ7] Trigger plus displacement: start active and displacement above start level.
// [RQ8] Trigger stop: time expiry or external input off.
// [RQ9] Time stop: expiry only, external input ignored.
// [RQ10] Load stop, start not above stop: load above both levels.
// [RQ11] Load stop, start above stop: arm at start, met at or below stop.
// [RQ12] Load-only stop: expiry or load condition, external input ignored.
// [RQ13] Displacement stop, start not above stop: above both levels.
// [RQ14] Displacement stop, start above stop: arm at start, met at or below stop.
// [RQ15] Displacement-only stop: expiry or displacement condition, input ignored.
// [RQ16] Repeat mode: after expiry wait 0.0 to 99.9 s, measure again.
// [RQ17] Repeat mode inhibits recording and digital zero.
// [RQ18] Zero wait: completed output pulses about 0.5 ms.
// [RQ19] Measuring time 0.1 to 30.0 seconds.
// [RQ20] Repeat mode resamples work at each completion.
// [RQ21] Repeat stops on input off, or second panel start if panel-started.
// [RQ22] Time counter starts at zero, expires at latched work's time.
// [RQ23] Simultaneous stop causes give one completion.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module measurement_cycle_sequencer #(
  parameter int TICK_CYCLES       = seq_pkg::TICK_CYCLES,
  parameter int DONE_PULSE_CYCLES = seq_pkg::DONE_PULSE_CYCLES
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [seq_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                 awprot,
  input  wire logic                       awvalid,
  output var  logic                       awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output var  logic                       wready,
  output var  logic [1:0]                 bresp,
  output var  logic                       bvalid,
  input  wire logic                       bready,
  input  wire logic [seq_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                 arprot,
  input  wire logic                       arvalid,
  output var  logic                       arready,
  output var  logic [31:0]                rdata,
  output var  logic [1:0]                 rresp,
  output var  logic                       rvalid,
  input  wire logic                       rready,
  input  wire logic                       work_select_in0,
  input  wire logic                       work_select_in1,
  input  wire logic                       work_select_in2,
  input  wire logic                       work_select_in3,
  input  wire logic                       start_stop_in,
  input  wire logic [seq_pkg::VAL_W-1:0]  load_value,
  input  wire logic [seq_pkg::VAL_W-1:0]  disp_value,
  output var  logic                       meas_done,
  output var  logic                       measuring,
  output var  logic [seq_pkg::WORK_W-1:0] active_work,
  output var  logic                       record_inhibit,
  output var  logic                       digital_zero_function_inhibit
);
  localparam int PRE_W = $clog2(TICK_CYCLES);
  localparam logic [PRE_W-1:0] PRE_END = PRE_W'(TICK_CYCLES - 1);
  localparam logic [PRE_W-1:0] PULSE_END = PRE_W'(DONE_PULSE_CYCLES - 1);

  seq_pkg::cond_type            cfg [seq_pkg::NUM_WORKS];
  seq_pkg::cond_type            cur;
  seq_pkg::cond_type            sel;
  seq_pkg::cond_type            edit;
  seq_pkg::state_type           state;
  logic [seq_pkg::WORK_W-1:0]   work;
  logic [seq_pkg::WORK_W-1:0]   manual_work;
  logic [seq_pkg::WORK_W-1:0]   edit_idx;
  logic [seq_pkg::WORK_W-1:0]   sel_work;
  logic                         work_source_pins;
  logic [4:0]                   pin_meta;
  logic [4:0]                   pin_sync;
  logic                         ext_prev;
  logic                         ext_on;
  logic                         ext_rise;
  logic                         ext_fall;
  logic                         panel_req;
  logic                         ext_pend;
  logic                         by_panel;
  logic [PRE_W-1:0]             pre;
  logic                         tick;
  logic [seq_pkg::WAIT_W-1:0]   tenths;
  logic                         load_armed;
  logic                         disp_armed;
  logic                         start_ok;
  logic                         expiry;
  logic                         load_met;
  logic                         disp_met;
  logic                         stop_now;
  logic                         repeat_on;
  logic                         abort;
  logic                         wait_over;
  logic                         go;
  logic                         enter_wait;
  logic                         panel_set;
  logic [seq_pkg::ADDR_W-1:0]   aw_addr;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic                         aw_held;
  logic                         w_held;
  logic                         do_write;
  logic [32:0]                  wr_old;
  logic [31:0]                  wr_mask;
  logic [31:0]                  wr_val;

  // register read mux: bit 32 flags a mapped address
  function automatic logic [32:0] reg_read(input logic [seq_pkg::ADDR_W-1:0] a);
    logic [31:0] d;
    logic        hit;
    d = '0;
    hit = 1'b1;
    if (a == seq_pkg::OFF_CTRL) begin
      d[seq_pkg::CTRL_SRC_BIT] = work_source_pins;
      d[seq_pkg::CTRL_MAN_LSB +: seq_pkg::WORK_W] = manual_work;
    end else if (a == seq_pkg::OFF_STATUS) begin
      d[seq_pkg::STAT_MEAS_BIT] = measuring;
      d[seq_pkg::STAT_DONE_BIT] = meas_done;
      d[seq_pkg::STAT_WAIT_BIT] = (state == seq_pkg::ST_WAIT);
      d[seq_pkg::STAT_REP_BIT] = record_inhibit;
      d[seq_pkg::STAT_WORK_LSB +: seq_pkg::WORK_W] = active_work;
    end else if (a == seq_pkg::OFF_EDIT) begin
      d[seq_pkg::WORK_W-1:0] = edit_idx;
    end else if (a == seq_pkg::OFF_MODES) begin
      d[1:0] = edit.start_mode;
      d[seq_pkg::MODE_STOP_LSB +: 3] = edit.stop_mode;
    end else if (a == seq_pkg::OFF_TIME) begin
      d[seq_pkg::TIME_W-1:0] = edit.meas_time;
    end else if (a == seq_pkg::OFF_WAIT) begin
      d[seq_pkg::WAIT_W-1:0] = edit.repeat_wait_setting;
    end else if (a == seq_pkg::OFF_START_LOAD) begin
      d[seq_pkg::VAL_W-1:0] = edit.start_load;
    end else if (a == seq_pkg::OFF_STOP_LOAD) begin
      d[seq_pkg::VAL_W-1:0] = edit.stop_load;
    end else if (a == seq_pkg::OFF_START_DISP) begin
      d[seq_pkg::VAL_W-1:0] = edit.start_disp;
    end else if (a == seq_pkg::OFF_STOP_DISP) begin
      d[seq_pkg::VAL_W-1:0] = edit.stop_disp;
    end else begin
      hit = 1'b0;
    end
    return {hit, d};
  endfunction

  // write channel: address and data taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
      bresp <= seq_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_held <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_held <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= wr_old[32] ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // byte lanes merge with the stored value so partial writes keep other bytes
  always_comb begin
    do_write = aw_held && w_held && !bvalid;
    wr_old = reg_read(aw_addr);
    wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wr_val = (wr_old[31:0] & ~wr_mask) | (w_data & wr_mask);
    panel_set = do_write && (aw_addr == seq_pkg::OFF_CTRL) && w_strb[1]
      && w_data[seq_pkg::CTRL_START_BIT];
  end

  // read channel, one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= seq_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= 32'(reg_read(araddr));
      rresp <= reg_read(araddr) >> 32 == 33'h0 ? seq_pkg::RESP_SLVERR : seq_pkg::RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // control registers and the sixteen condition sets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      work_source_pins <= 1'b0;
      manual_work <= '0;
      edit_idx <= '0;
      for (int i = 0; i < seq_pkg::NUM_WORKS; i++) begin
        cfg[i] <= '{start_mode: seq_pkg::START_TRIG, stop_mode: seq_pkg::STOP_TRIG,
          meas_time: seq_pkg::MEAS_RST, default: '0};
      end
    end else if (do_write) begin
      if (aw_addr == seq_pkg::OFF_CTRL) begin
        work_source_pins <= wr_val[seq_pkg::CTRL_SRC_BIT]; // [RQ2]
        manual_work <= wr_val[seq_pkg::CTRL_MAN_LSB +: seq_pkg::WORK_W];
      end else if (aw_addr == seq_pkg::OFF_EDIT) begin
        edit_idx <= wr_val[seq_pkg::WORK_W-1:0];
      end else if (aw_addr == seq_pkg::OFF_MODES) begin
        cfg[edit_idx].start_mode <= wr_val[1:0];
        cfg[edit_idx].stop_mode <= wr_val[seq_pkg::MODE_STOP_LSB +: 3];
      end else if (aw_addr == seq_pkg::OFF_TIME) begin
        // out-of-range times clamp to the legal span
        if (wr_val[31:seq_pkg::TIME_W] != '0 || wr_val[seq_pkg::TIME_W-1:0] > seq_pkg::MEAS_MAX)
          cfg[edit_idx].meas_time <= seq_pkg::MEAS_MAX; // [RQ19]
        else if (wr_val[seq_pkg::TIME_W-1:0] < seq_pkg::MEAS_MIN)
          cfg[edit_idx].meas_time <= seq_pkg::MEAS_MIN; // [RQ19]
        else
          cfg[edit_idx].meas_time <= wr_val[seq_pkg::TIME_W-1:0];
      end else if (aw_addr == seq_pkg::OFF_WAIT) begin
        if (wr_val[31:seq_pkg::WAIT_W] != '0 || wr_val[seq_pkg::WAIT_W-1:0] > seq_pkg::WAIT_MAX)
          cfg[edit_idx].repeat_wait_setting <= seq_pkg::WAIT_MAX; // [RQ16]
        else
          cfg[edit_idx].repeat_wait_setting <= wr_val[seq_pkg::WAIT_W-1:0];
      end else if (aw_addr == seq_pkg::OFF_START_LOAD) begin
        cfg[edit_idx].start_load <= wr_val[seq_pkg::VAL_W-1:0];
      end else if (aw_addr == seq_pkg::OFF_STOP_LOAD) begin
        cfg[edit_idx].stop_load <= wr_val[seq_pkg::VAL_W-1:0];
      end else if (aw_addr == seq_pkg::OFF_START_DISP) begin
        cfg[edit_idx].start_disp <= wr_val[seq_pkg::VAL_W-1:0];
      end else if (aw_addr == seq_pkg::OFF_STOP_DISP) begin
        cfg[edit_idx].stop_disp <= wr_val[seq_pkg::VAL_W-1:0];
      end
    end
  end

  // pin synchroniser; only the second stage feeds logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
      ext_prev <= 1'b0;
    end else begin
      pin_meta <= {start_stop_in, work_select_in3, work_select_in2, work_select_in1,
        work_select_in0};
      pin_sync <= pin_meta;
      ext_prev <= pin_sync[4];
    end
  end

  // start requests; a new request in the clearing cycle is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      panel_req <= 1'b0;
      ext_pend <= 1'b0;
    end else begin
      if (panel_set)
        panel_req <= 1'b1;
      else if (go || (state != seq_pkg::ST_IDLE && panel_req))
        panel_req <= 1'b0;
      if (ext_rise)
        ext_pend <= 1'b1;
      else if (go || ext_fall)
        ext_pend <= 1'b0;
    end
  end

  // time base: 0.1 s ticks, restarted with every phase so counts begin at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre <= '0;
      tenths <= '0;
    end else if (go || enter_wait) begin
      pre <= '0; // [RQ22]
      tenths <= '0; // [RQ22]
    end else begin
      pre <= tick ? '0 : pre + 1'b1;
      if (tick && tenths != seq_pkg::TENTHS_SAT)
        tenths <= tenths + 1'b1;
    end
  end

  // falling-threshold arming, cleared at each start
  always_ff @(posedge aclk) begin
    if (!aresetn || go) begin
      load_armed <= 1'b0;
      disp_armed <= 1'b0;
    end else if (state == seq_pkg::ST_MEAS) begin
      if ($signed(load_value) >= $signed(cur.start_load))
        load_armed <= 1'b1; // [RQ11]
      if ($signed(disp_value) >= $signed(cur.start_disp))
        disp_armed <= 1'b1; // [RQ14]
    end
  end

  // start and stop decisions
  always_comb begin
    ext_on = pin_sync[4];
    ext_rise = ext_on && !ext_prev;
    ext_fall = ext_prev && !ext_on;
    // pin code 0..15 selects work 0..15
    sel_work = work_source_pins ? pin_sync[3:0] : manual_work; // [RQ3]
    sel = cfg[sel_work];
    cur = cfg[work]; // [RQ1]
    edit = cfg[edit_idx];
    tick = (pre == PRE_END);
    start_ok = 1'b0;
    if (panel_req || (ext_pend && ext_on)) begin
      if (sel.start_mode == seq_pkg::START_LOAD)
        start_ok = $signed(load_value) > $signed(sel.start_load); // [RQ6]
      else if (sel.start_mode == seq_pkg::START_DISP)
        start_ok = $signed(disp_value) > $signed(sel.start_disp); // [RQ7]
      else
        start_ok = 1'b1; // [RQ5]
    end
    expiry = tenths >= seq_pkg::WAIT_W'(cur.meas_time); // [RQ22]
    if ($signed(cur.start_load) <= $signed(cur.stop_load))
      load_met = $signed(load_value) > $signed(cur.start_load)
        && $signed(load_value) > $signed(cur.stop_load); // [RQ10]
    else
      load_met = load_armed && $signed(load_value) <= $signed(cur.stop_load); // [RQ11]
    if ($signed(cur.start_disp) <= $signed(cur.stop_disp))
      disp_met = $signed(disp_value) > $signed(cur.start_disp)
        && $signed(disp_value) > $signed(cur.stop_disp); // [RQ13]
    else
      disp_met = disp_armed && $signed(disp_value) <= $signed(cur.stop_disp); // [RQ14]
    case (cur.stop_mode)
      seq_pkg::STOP_TRIG:      stop_now = expiry || ext_fall; // [RQ8]
      seq_pkg::STOP_TIME:      stop_now = expiry; // [RQ9]
      seq_pkg::STOP_TRIG_LOAD: stop_now = expiry || ext_fall || load_met; // [RQ10]
      seq_pkg::STOP_LOAD:      stop_now = expiry || load_met; // [RQ12]
      seq_pkg::STOP_TRIG_DISP: stop_now = expiry || ext_fall || disp_met; // [RQ13]
      seq_pkg::STOP_DISP:      stop_now = expiry || disp_met; // [RQ15]
      default:                 stop_now = expiry; // [RQ16]
    endcase
    repeat_on = (cur.stop_mode == seq_pkg::STOP_REPEAT);
    abort = repeat_on && (by_panel ? panel_req : ext_fall); // [RQ21]
    // zero wait still holds the completed output for one short pulse
    wait_over = (cur.repeat_wait_setting == seq_pkg::WAIT_ZERO) ? (pre == PULSE_END)
      : (tenths >= cur.repeat_wait_setting); // [RQ16] [RQ18]
    go = (state == seq_pkg::ST_IDLE && start_ok)
      || (state == seq_pkg::ST_WAIT && wait_over && !abort);
    enter_wait = state == seq_pkg::ST_MEAS && !abort && stop_now && repeat_on;
  end

  // cycle sequencer; a single transition per end makes one completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= seq_pkg::ST_IDLE;
      work <= '0;
      by_panel <= 1'b0;
      meas_done <= 1'b0;
      measuring <= 1'b0;
    end else begin
      case (state)
        seq_pkg::ST_IDLE: begin
          if (start_ok) begin
            state <= seq_pkg::ST_MEAS;
            work <= sel_work; // [RQ4]
            by_panel <= panel_req;
            meas_done <= 1'b0;
            measuring <= 1'b1;
          end
        end
        seq_pkg::ST_MEAS: begin
          if (abort || stop_now) begin
            meas_done <= 1'b1; // [RQ23]
            measuring <= 1'b0;
            state <= enter_wait ? seq_pkg::ST_WAIT : seq_pkg::ST_IDLE;
            if (enter_wait)
              work <= sel_work; // [RQ20]
          end
        end
        seq_pkg::ST_WAIT: begin
          if (abort) begin
            state <= seq_pkg::ST_IDLE; // [RQ21]
          end else if (wait_over) begin
            state <= seq_pkg::ST_MEAS; // [RQ16]
            meas_done <= 1'b0; // [RQ18]
            measuring <= 1'b1;
          end
        end
        default: state <= seq_pkg::ST_IDLE;
      endcase
    end
  end

  // status outputs, one cycle behind the sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_work <= '0;
      record_inhibit <= 1'b0;
      digital_zero_function_inhibit <= 1'b0;
    end else begin
      active_work <= work;
      record_inhibit <= repeat_on && state != seq_pkg::ST_IDLE; // [RQ17]
      digital_zero_function_inhibit <= repeat_on && state != seq_pkg::ST_IDLE; // [RQ17]
    end
  end
endmodule
`default_nettype wire

// *** measurement_cycle_sequencer_checker.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/100ps
`default_nettype none
module measurement_cycle_sequencer_checker (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       arvalid,
  input wire logic                       arready,
  input wire logic                       rvalid,
  input wire logic                       meas_done,
  input wire logic                       measuring,
  input wire logic [seq_pkg::WORK_W-1:0] active_work,
  input wire logic                       record_inhibit,
  input wire logic                       digital_zero_function_inhibit
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_done_once; $rose(meas_done) |-> $fell(measuring); endproperty
  a_done_once: assert property (p_done_once) else $error("completion without end");
  property p_excl; meas_done |-> !measuring; endproperty
  a_excl: assert property (p_excl) else $error("completed while measuring");
  property p_start_clr; $rose(measuring) |-> !meas_done; endproperty
  a_start_clr: assert property (p_start_clr) else $error("done kept at start");
  property p_done_holds; $fell(meas_done) |-> measuring; endproperty
  a_done_holds: assert property (p_done_holds) else $error("done dropped in idle");
  property p_inhib; record_inhibit == digital_zero_function_inhibit; endproperty
  a_inhib: assert property (p_inhib) else $error("inhibits disagree");
  // latch lands one cycle after start, so skip the first two cycles
  property p_work_hold;
    measuring && $past(measuring) && $past(measuring, 2) |-> $stable(active_work);
  endproperty
  a_work_hold: assert property (p_work_hold) else $error("work changed mid run");
  property p_rd_ans; arvalid && arready |=> rvalid && !arready; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_rd_busy; rvalid |-> !arready; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read taken while busy");
  c_start: cover property ($rose(measuring));
  c_done: cover property ($rose(meas_done));
  c_repeat: cover property (record_inhibit && measuring);
endmodule
bind measurement_cycle_sequencer measurement_cycle_sequencer_checker u_chk (.aclk, .aresetn,
  .arvalid, .arready, .rvalid, .meas_done, .measuring, .active_work, .record_inhibit,
  .digital_zero_function_inhibit);
`default_nettype wire

// *** machine_ctrl_model.sv ***
// external controller model: work select pins and start/stop input
`timescale 1ns/100ps
`default_nettype none
module machine_ctrl_model (
  input  wire logic       aclk,
  output var  logic [3:0] work_pins,
  output var  logic       start_stop_in
);
  initial work_pins = 4'h0;
  initial start_stop_in = 1'b0;
  // new work held for the synchroniser before any start
  task automatic sel(input logic [3:0] w);
    @(posedge aclk) work_pins <= w;
    repeat (4) @(posedge aclk);
  endtask
  // level start/stop, dropping it ends trigger or repeat runs
  task automatic pin(input logic v);
    @(posedge aclk) start_stop_in <= v;
  endtask
endmodule
`default_nettype wire

// *** measurement_cycle_sequencer_tb_top.sv ***
// self-checking bench for the measurement cycle sequencer
`timescale 1ns/100ps
`default_nettype none
module measurement_cycle_sequencer_tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [15:0] load_value = 16'h0000, disp_value = 16'h0000;
  logic [1:0]  bresp, rresp, e;
  logic [3:0]  wp, active_work, wstrb = 4'hF;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid, meas_done, measuring, ss;
  logic        record_inhibit, digital_zero_function_inhibit;
  int          fail_count = 0, n_compared = 0, cyc = 0, n;
  // short tick keeps each 0.1 s step at 50 cycles
  measurement_cycle_sequencer #(.TICK_CYCLES(50), .DONE_PULSE_CYCLES(10))
    u_measurement_cycle_sequencer (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .work_select_in0(wp[0]), .work_select_in1(wp[1]),
    .work_select_in2(wp[2]), .work_select_in3(wp[3]), .start_stop_in(ss), .load_value,
    .disp_value, .meas_done, .measuring, .active_work, .record_inhibit,
    .digital_zero_function_inhibit);
  machine_ctrl_model m (.aclk, .work_pins(wp), .start_stop_in(ss));
  always #25 aclk = ~aclk;
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // bus tasks sample ready at the rising edge, as the slave does
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk) {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    e = bresp;
    bready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    @(posedge aclk) {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    {d, e} = {rdata, rresp};
    rready <= 1'b0;
    chk(d, x);
  endtask
  task automatic cfg(input logic [3:0] i, input logic [7:0] md, input logic [8:0] t);
    wr(seq_pkg::OFF_EDIT, {28'h0, i});
    wr(seq_pkg::OFF_MODES, {24'h0, md});
    wr(seq_pkg::OFF_TIME, {23'h0, t});
  endtask
  task automatic tmeas();
    do @(negedge aclk); while (measuring !== 1'b1);
  endtask
  task automatic tdone();
    n = 0;
    do begin @(negedge aclk); n++; end while (meas_done !== 1'b1);
  endtask
  // tests in sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(seq_pkg::OFF_STATUS, 32'h0);
    rc(seq_pkg::OFF_TIME, 32'h0000000A);
    wr(seq_pkg::OFF_TIME, 32'h0);
    rc(seq_pkg::OFF_TIME, 32'h00000001);
    wr(seq_pkg::OFF_TIME, 32'h000001F4);
    rc(seq_pkg::OFF_TIME, 32'h0000012C);
    rc(8'h40, 32'h0);
    chk(32'(e), 32'(seq_pkg::RESP_SLVERR));
    $display("test registers done");
    cfg(4'h2, 8'h00, 9'h00A);
    wr(seq_pkg::OFF_CTRL, 32'h00000001);
    m.sel(4'h2);
    m.pin(1'b1);
    tmeas();
    repeat (3) @(negedge aclk);
    chk(32'(active_work), 32'h2);
    m.sel(4'h7);
    m.pin(1'b0);
    tdone();
    chk(32'(n < 8), 32'h1);
    chk(32'(active_work), 32'h2);
    $display("test trigger stop done");
    cfg(4'h1, 8'h10, 9'h002);
    m.sel(4'h1);
    m.pin(1'b1);
    tmeas();
    m.pin(1'b0);
    tdone();
    chk(32'(n >= 97 && n <= 101), 32'h1);
    $display("test time stop done");
    cfg(4'h3, 8'h31, 9'h00A);
    wr(seq_pkg::OFF_START_LOAD, 32'h00000064);
    wr(seq_pkg::OFF_STOP_LOAD, 32'h000000C8);
    m.sel(4'h3);
    @(posedge aclk) load_value <= 16'h0064;
    m.pin(1'b1);
    repeat (10) @(negedge aclk);
    chk(32'(measuring), 32'h0);
    @(posedge aclk) load_value <= 16'h0065;
    tmeas();
    m.pin(1'b0);
    repeat (10) @(negedge aclk);
    chk(32'(measuring), 32'h1);
    @(posedge aclk) load_value <= 16'h00C9;
    tdone();
    chk(32'(n < 5), 32'h1);
    $display("test load start stop done");
    cfg(4'h5, 8'h60, 9'h001);
    wr(seq_pkg::OFF_CTRL, 32'h00000050);
    wr(seq_pkg::OFF_CTRL, 32'h00000150);
    tmeas();
    repeat (3) @(negedge aclk);
    chk(32'({record_inhibit, digital_zero_function_inhibit}), 32'h3);
    tdone();
    n = 0;
    while (meas_done === 1'b1) begin n++; @(negedge aclk); end
    chk(32'(n), 32'd10);
    chk(32'(measuring), 32'h1);
    wr(seq_pkg::OFF_CTRL, 32'h00000150);
    tdone();
    repeat (30) @(negedge aclk);
    chk(32'({measuring, meas_done}), 32'h1);
    $display("test repeat done");
    summarize();
  end
endmodule
`default_nettype wire
